// ### fsw_consts.svh
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// register offsets
`define FSW_OFS_PRESCALE 16'h0400
`define FSW_OFS_LOCAL_TMO 16'h0410
`define FSW_OFS_PROC_TMO 16'h0420

// reset values
`define FSW_RST_PRESCALE 16'h09C2
`define FSW_RST_PROC_TMO 16'h03E8
`define FSW_RST_LOCAL_TMO 16'h03E8

// timing
`define FSW_CLK_PERIOD_NS 20
`define FSW_BASE_TICK_NS 40
`define FSW_BASE_CYCLES ((`FSW_BASE_TICK_NS + `FSW_CLK_PERIOD_NS - 1) / `FSW_CLK_PERIOD_NS)
`define FSW_PRESCALE_EXTRA 2

// watchdog indices inside the generate loop
`define FSW_WD_PROC 0
`define FSW_WD_LOCAL 1
`define FSW_WD_COUNT 2

`endif

// ### fsw_pkg.sv
package fsw_pkg;

    typedef enum logic [2:0] {
        FSW_WD_IDLE    = 3'b001,
        FSW_WD_RUN     = 3'b010,
        FSW_WD_EXPIRED = 3'b100
    } fsw_wd_state_t;

endpackage

// ### fsw_tick.sv
`timescale 1ns/1ns
`include "fsw_consts.svh"

module fsw_tick
    import fsw_pkg::*;
#(
    parameter int PW = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [PW-1:0] prescale_i,
    output logic wd_tick_o
);

    localparam logic [7:0] BASE_LAST = 8'(`FSW_BASE_CYCLES - 1);
    localparam logic [PW:0] EXTRA_LAST = (PW+1)'(`FSW_PRESCALE_EXTRA - 1);

    logic [7:0] base_cnt_ff;
    logic base_tick;
    logic [PW:0] presc_cnt_ff;
    logic [PW:0] presc_last;

    assign base_tick = (base_cnt_ff == BASE_LAST);
    // one watchdog tick spans prescale + 2 base ticks
    assign presc_last = {1'b0, prescale_i} + EXTRA_LAST;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            base_cnt_ff <= 8'h00;
        end else if (base_tick) begin
            base_cnt_ff <= 8'h00;
        end else begin
            base_cnt_ff <= base_cnt_ff + 8'h01;
        end
    end

    // a prescale rewrite below the running count wraps at once rather than running to the top
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            presc_cnt_ff <= '0;
        end else if (base_tick) begin
            if (presc_cnt_ff >= presc_last) begin
                presc_cnt_ff <= '0;
            end else begin
                presc_cnt_ff <= presc_cnt_ff + (PW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wd_tick_o <= 1'b0;
        end else begin
            wd_tick_o <= base_tick && (presc_cnt_ff >= presc_last);
        end
    end

endmodule // fsw_tick

// ### fsw_top.sv
`timescale 1ns/1ns
`include "fsw_consts.svh"


module fsw_top
    import fsw_pkg::*;
#(
    parameter int OW = 8,
    parameter logic [OW-1:0] SAFE_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic pd_exchange_ok_i,
    input wire logic local_access_i,
    input wire logic [OW-1:0] app_out_i,
    output logic [OW-1:0] out_o,
    output logic proc_wd_expired_o,
    output logic local_wd_expired_o
);

    localparam int TW = 16;

    logic [TW-1:0] prescale_ff;
    logic [TW-1:0] proc_tmo_ff;
    logic [TW-1:0] local_tmo_ff;
    logic wd_tick;
    logic [TW-1:0] tmo [`FSW_WD_COUNT];
    logic [`FSW_WD_COUNT-1:0] kick;
    logic [`FSW_WD_COUNT-1:0] wd_exp;
    logic [`FSW_WD_COUNT-1:0] wd_exp_evt;
    logic any_exp;

    // register writes; unwritten values simply persist, so a master that skips
    // a setting at startup leaves the held value in force
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            prescale_ff <= `FSW_RST_PRESCALE;
            proc_tmo_ff <= `FSW_RST_PROC_TMO;
            local_tmo_ff <= `FSW_RST_LOCAL_TMO;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `FSW_OFS_PRESCALE: begin
                    prescale_ff <= reg_wdata_i;
                end
                `FSW_OFS_LOCAL_TMO: begin
                    local_tmo_ff <= reg_wdata_i;
                end
                `FSW_OFS_PROC_TMO: begin
                    proc_tmo_ff <= reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // reads return one cycle later; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `FSW_OFS_PRESCALE: begin
                    reg_rdata_o <= prescale_ff;
                end
                `FSW_OFS_LOCAL_TMO: begin
                    reg_rdata_o <= local_tmo_ff;
                end
                `FSW_OFS_PROC_TMO: begin
                    reg_rdata_o <= proc_tmo_ff;
                end
                default: begin
                    reg_rdata_o <= 16'h0000;
                end
            endcase
        end
    end

    // single prescaler feeds both watchdogs
    fsw_tick #(
        .PW(TW)
    ) u_tick (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .prescale_i(prescale_ff),
        .wd_tick_o(wd_tick)
    );

    assign tmo[`FSW_WD_PROC] = proc_tmo_ff;
    assign tmo[`FSW_WD_LOCAL] = local_tmo_ff;
    assign kick[`FSW_WD_PROC] = pd_exchange_ok_i;
    assign kick[`FSW_WD_LOCAL] = local_access_i;

    // prescaler runs free, so a kick restarts the count but not the tick phase:
    // real timeout lies between (value-1) and value ticks after the last kick
    for (genvar g = 0; g < `FSW_WD_COUNT; g++) begin : g_wd
        fsw_wd_state_t st_ff;
        logic [TW-1:0] cnt_ff;
        logic cnt_done;

        // timeout is register value times watchdog tick
        assign cnt_done = ({1'b0, cnt_ff} + 17'h00001) >= {1'b0, tmo[g]};

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                st_ff <= FSW_WD_IDLE;
                cnt_ff <= '0;
            end else begin
                case (st_ff)
                    FSW_WD_IDLE: begin
                        cnt_ff <= '0;
                        if (tmo[g] != '0) begin
                            st_ff <= FSW_WD_RUN;
                        end
                    end
                    FSW_WD_RUN: begin
                        if (tmo[g] == '0) begin
                            st_ff <= FSW_WD_IDLE;
                        end else if (kick[g]) begin
                            cnt_ff <= '0;
                        end else if (wd_tick) begin
                            if (cnt_done) begin
                                st_ff <= FSW_WD_EXPIRED;
                                cnt_ff <= '0;
                            end else if (cnt_ff != '1) begin
                                cnt_ff <= cnt_ff + 16'h0001;
                            end
                        end
                    end
                    FSW_WD_EXPIRED: begin
                        if (tmo[g] == '0) begin
                            st_ff <= FSW_WD_IDLE;
                        end else if (kick[g]) begin
                            st_ff <= FSW_WD_RUN;
                            cnt_ff <= '0;
                        end
                    end
                    default: begin
                        st_ff <= FSW_WD_IDLE;
                        cnt_ff <= '0;
                    end
                endcase
            end
        end

        assign wd_exp[g] = (st_ff == FSW_WD_EXPIRED);
        assign wd_exp_evt[g] = (st_ff == FSW_WD_RUN) && !kick[g] && wd_tick && cnt_done && (tmo[g] != '0);
    end

    assign any_exp = |wd_exp;

    // flags set on the same edge as the expired state and clear one cycle after it; expiry has no path into the slave
    // state machine, so the operational state is never touched here
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            proc_wd_expired_o <= 1'b0;
            local_wd_expired_o <= 1'b0;
        end else begin
            proc_wd_expired_o <= wd_exp[`FSW_WD_PROC] || wd_exp_evt[`FSW_WD_PROC];
            local_wd_expired_o <= wd_exp[`FSW_WD_LOCAL] || wd_exp_evt[`FSW_WD_LOCAL];
        end
    end

    // output stage: safe value while any watchdog is expired; a disabled
    // watchdog never expires, so outputs pass through on lost links
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            out_o <= SAFE_VALUE;
        end else if (any_exp || (|wd_exp_evt)) begin
            out_o <= SAFE_VALUE;
        end else begin
            out_o <= app_out_i;
        end
    end

endmodule // fsw_top

// ### fsw_top_props.sv
`timescale 1ns/1ns
module fsw_top_props #(
    parameter int OW = 8,
    parameter logic [OW-1:0] SAFE_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic pd_exchange_ok_i,
    input wire logic local_access_i,
    input wire logic [OW-1:0] app_out_i,
    input wire logic [OW-1:0] out_o,
    input wire logic proc_wd_expired_o,
    input wire logic local_wd_expired_o
);
    logic [15:0] pre_ff, ptmo_ff, ltmo_ff;
    logic [23:0] pcnt_ff, lcnt_ff;
    logic quiet_ff;
    logic [31:0] tk, plim, llim;
    // two system clocks per base tick
    assign tk = (32'(pre_ff) + 32'h2) * 32'h2;
    assign plim = tk * 32'(ptmo_ff);
    assign llim = tk * 32'(ltmo_ff);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pre_ff <= 16'h09C2;
            ptmo_ff <= 16'h03E8;
            ltmo_ff <= 16'h03E8;
        end else if (reg_wr_i) begin
            if (reg_addr_i == 16'h0400) pre_ff <= reg_wdata_i;
            if (reg_addr_i == 16'h0410) ltmo_ff <= reg_wdata_i;
            if (reg_addr_i == 16'h0420) ptmo_ff <= reg_wdata_i;
        end
    end
    // saturate so a long silence never wraps back to looking fresh
    always_ff @(posedge clk_i) begin
        pcnt_ff <= (!resetn_i || pd_exchange_ok_i) ? 24'h0 : pcnt_ff + 24'(pcnt_ff != 24'hFFFFFF);
        lcnt_ff <= (!resetn_i || local_access_i) ? 24'h0 : lcnt_ff + 24'(lcnt_ff != 24'hFFFFFF);
        quiet_ff <= resetn_i && !proc_wd_expired_o && !local_wd_expired_o;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    AST_SAFE: assert property ((proc_wd_expired_o || local_wd_expired_o) |-> out_o == SAFE_VALUE)
        else $error("outputs not safe while expired");
    AST_PASS: assert property (quiet_ff && !proc_wd_expired_o && !local_wd_expired_o |-> out_o == $past(app_out_i))
        else $error("outputs not passed through");
    AST_PZERO: assert property (ptmo_ff == 16'h0 |=> !proc_wd_expired_o)
        else $error("disabled watchdog expired");
    AST_PLO: assert property ($rose(proc_wd_expired_o) |-> 32'(pcnt_ff) + tk > plim)
        else $error("process watchdog expired early");
    AST_PHI: assert property (ptmo_ff != 16'h0 && 32'(pcnt_ff) == plim |-> proc_wd_expired_o)
        else $error("process watchdog expired late");
    AST_LLO: assert property ($rose(local_wd_expired_o) |-> 32'(lcnt_ff) + tk > llim)
        else $error("local watchdog expired early");
    AST_LHI: assert property (ltmo_ff != 16'h0 && 32'(lcnt_ff) == llim |-> local_wd_expired_o)
        else $error("local watchdog expired late");
    AST_RDP: assert property (reg_rd_i && reg_addr_i == 16'h0420 |=> reg_rdata_o == $past(ptmo_ff))
        else $error("timeout readback wrong");
endmodule // fsw_top_props
bind fsw_top fsw_top_props #(.OW(OW), .SAFE_VALUE(SAFE_VALUE)) props_u (.clk_i, .resetn_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pd_exchange_ok_i, .local_access_i, .app_out_i, .out_o,
    .proc_wd_expired_o, .local_wd_expired_o);

// ### fsw_peer.sv
`timescale 1ns/1ns
module fsw_peer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic pd_en_i,
    input wire logic lc_en_i,
    output logic pd_ok_o = 1'b0,
    output logic lc_acc_o = 1'b0
);
    logic [1:0] gap_ff = 2'h0;
    // both parties talk every fourth cycle; a stopped party simply falls silent
    always @(posedge clk_i) begin
        gap_ff <= gap_ff + 2'h1;
        pd_ok_o <= resetn_i && pd_en_i && gap_ff == 2'h0;
        lc_acc_o <= resetn_i && lc_en_i && gap_ff == 2'h2;
    end
endmodule // fsw_peer

// ### fsw_top_tb_top.sv
`timescale 1ns/1ns
module fsw_top_tb_top;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, pd_en = 1'b0, lc_en = 1'b0;
    logic [15:0] reg_addr_i = 16'h0, reg_wdata_i = 16'h0, reg_rdata_o;
    logic [7:0] app_out_i = 8'hA5, out_o;
    logic pd_exchange_ok_i, local_access_i, proc_wd_expired_o, local_wd_expired_o;
    int err_total = 0, check_count = 0;
    always #10 clk_i = ~clk_i;
    fsw_top dut_u (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .pd_exchange_ok_i, .local_access_i, .app_out_i, .out_o, .proc_wd_expired_o, .local_wd_expired_o);
    fsw_peer peer_u (.clk_i, .resetn_i, .pd_en_i(pd_en), .lc_en_i(lc_en), .pd_ok_o(pd_exchange_ok_i),
        .lc_acc_o(local_access_i));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask
    // settle past the edge so flags are read after the design updates
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(16'h0400, 16'h09C2);
        rd(16'h0410, 16'h03E8);
        rd(16'h0420, 16'h03E8);
        wr(16'h0430, 16'h1234);
        rd(16'h0430, 16'h0000);
        $display("reset test done");
        wr(16'h0400, 16'h0000);
        wr(16'h0420, 16'h0003);
        rd(16'h0420, 16'h0003);
        @(posedge clk_i) pd_en <= 1'b1;
        lc_en <= 1'b1;
        wt(60);
        chk(16'(proc_wd_expired_o), 16'h0);
        chk(16'(out_o), 16'h00A5);
        @(posedge clk_i) pd_en <= 1'b0;
        wt(16);
        chk(16'(proc_wd_expired_o), 16'h1);
        chk(16'(out_o), 16'h0000);
        @(posedge clk_i) pd_en <= 1'b1;
        wt(10);
        chk(16'(proc_wd_expired_o), 16'h0);
        chk(16'(out_o), 16'h00A5);
        $display("process test done");
        @(posedge clk_i) pd_en <= 1'b0;
        wr(16'h0420, 16'h0000);
        wt(40);
        chk(16'(proc_wd_expired_o), 16'h0);
        chk(16'(out_o), 16'h00A5);
        $display("disable test done");
        @(posedge clk_i) lc_en <= 1'b0;
        wr(16'h0410, 16'h0002);
        wt(16);
        chk(16'(local_wd_expired_o), 16'h1);
        chk(16'(out_o), 16'h0000);
        @(posedge clk_i) lc_en <= 1'b1;
        wt(10);
        chk(16'(local_wd_expired_o), 16'h0);
        $display("local test done");
        end_of_test();
    end
endmodule // fsw_top_tb_top
